// ===== common/swg_cfg.svh
// constants for the startup wait gating block
// assumes inclusion by bare name from design files
`ifndef SWG_CFG_SVH
`define SWG_CFG_SVH
`define SWG_NUM_UNITS 4
`define SWG_NUM_BOARDS 2
`define SWG_POLICY_WAIT_ALL 1'b0
`define SWG_POLICY_EARLY 1'b1
`define SWG_BOARD_WAIT 1'b0
`define SWG_BOARD_SKIP 1'b1
`define SWG_MODE_PROGRAM 1'b0
`define SWG_MODE_MONITOR 1'b1
`endif

// ===== common/swg_pkg.sv
// types for the startup wait gating block
// assumes swg_cfg.svh supplies the numeric constants
package swg_pkg;
   // sequencer states
   typedef enum logic [1:0] {
      SWG_ST_RESET = 2'b00,
      SWG_ST_STANDBY = 2'b01,
      SWG_ST_RUN = 2'b10
   } swg_state_e;
endpackage : swg_pkg

// ===== common/swg_sync_if.sv
// carrier between the top and its synchroniser bank
// assumes one clock domain on both sides
`timescale 1ns/1ns
interface swg_sync_if #(parameter int W = 1);
   logic [W-1:0] raw; // pin levels
   logic [W-1:0] sync; // synchronised levels
   modport src (output raw, input sync);
   modport snk (input raw, output sync);
endinterface : swg_sync_if

// ===== hw/swg_sync.sv
// two-flop synchroniser bank for the done levels
// assumes pins are asynchronous to i_clk
`timescale 1ns/1ns
module swg_sync (
   input wire logic i_clk,
   input wire logic i_rst,
   swg_sync_if.snk bus
);
   logic [$bits(bus.raw)-1:0] meta_r; // first stage, read only by stage two
   logic [$bits(bus.raw)-1:0] sync_r; // second stage
   // both stages clear to not-done under reset
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= bus.raw;
         sync_r <= meta_r;
      end
   end
   assign bus.sync = sync_r;
endmodule : swg_sync

// ===== hw/swg_startup_gate.sv
// startup wait gating: holds the processor in standby until policy allows start
// releases once, then stays released until the next reset
// assumes done levels from units and boards are asynchronous pins, setup bits static
// assumes one clock, asynchronous active-high reset, no software-visible registers
`timescale 1ns/1ns
`include "swg_cfg.svh"
module swg_startup_gate #(
   parameter int NUM_UNITS = `SWG_NUM_UNITS,
   parameter int NUM_BOARDS = `SWG_NUM_BOARDS
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [NUM_UNITS-1:0] i_unit_done,   // unit startup complete levels
   input wire logic [NUM_BOARDS-1:0] i_board_done, // board startup complete levels
   input wire logic i_wait_policy,                 // 1 enables early start
   input wire logic i_board_skip,                  // 1 skips boards in early start
   input wire logic i_start_mode,                  // monitor or program mode select
   output logic o_cpu_run,                         // processor released from standby
   output logic o_standby,                         // processor held in standby
   output logic o_mode_monitor,                    // start mode latched at release
   output logic o_all_done                         // every unit and board done
);
   // synchroniser width: every done level plus the three setup bits
   localparam int W = NUM_UNITS + NUM_BOARDS + 3;
   // carrier to the synchroniser bank
   swg_sync_if #(.W(W)) sif ();
   // one bank for all pins keeps their latency equal
   swg_sync u_sync (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .bus(sif)
   );
   // setup bits pass the synchroniser too, being pins
   assign sif.raw = {i_start_mode, i_board_skip, i_wait_policy, i_board_done, i_unit_done};

   // synchronised copies, the only versions the logic reads
   logic [NUM_UNITS-1:0] unit_s; // unit done levels
   logic [NUM_BOARDS-1:0] board_s; // board done levels
   logic policy_s; // early-start enable
   logic skip_s; // board skip in early start
   logic mode_s; // 1 monitor, 0 program
   // unpack in the order packed above
   assign unit_s = sif.sync[NUM_UNITS-1:0];
   assign board_s = sif.sync[NUM_UNITS+NUM_BOARDS-1:NUM_UNITS];
   assign policy_s = sif.sync[W-3];
   assign skip_s = sif.sync[W-2];
   assign mode_s = sif.sync[W-1];

   logic units_ok; // all units finished
   logic boards_ok; // all boards finished
   logic may_start; // policy permits release
   assign units_ok = &unit_s;
   assign boards_ok = &board_s;

   // start decision per policy
   // under reset every synced level reads 0, i.e. wait-all with nothing done,
   // so the first standby cycles can never release on stale setup bits
   always_comb begin
      // wait-all: the board skip bit is not looked at
      if (policy_s == `SWG_POLICY_WAIT_ALL) begin
         may_start = units_ok && boards_ok;
      end else if (skip_s == `SWG_BOARD_WAIT) begin
         may_start = boards_ok;
      end else begin
         may_start = 1'b1;
      end
   end

   // sequencer state and the registered outputs
   swg_pkg::swg_state_e state_r, state_nxt; // sequencer position
   logic run_r, run_nxt; // released flag
   logic stby_r, stby_nxt; // standby flag
   logic mon_r, mon_nxt; // start mode, frozen at release
   logic all_r, all_nxt; // every unit and board done

   // sequencer: one reset cycle, then standby until the policy allows release
   // release is one-way: a late level change cannot put the processor back
   always_comb begin
      state_nxt = state_r;
      run_nxt = run_r;
      stby_nxt = stby_r;
      mon_nxt = mon_r;
      all_nxt = units_ok && boards_ok;
      case (state_r)
         // first cycle out of reset: enter standby, never release here
         swg_pkg::SWG_ST_RESET: begin
            state_nxt = swg_pkg::SWG_ST_STANDBY;
            stby_nxt = 1'b1;
         end
         // standby: follow the mode pin until the release edge
         swg_pkg::SWG_ST_STANDBY: begin
            mon_nxt = mode_s;
            if (may_start) begin
               state_nxt = swg_pkg::SWG_ST_RUN;
               run_nxt = 1'b1;
               stby_nxt = 1'b0;
            end
         end
         swg_pkg::SWG_ST_RUN: begin
            // release is final; late finishers do not re-gate
            run_nxt = 1'b1;
            stby_nxt = 1'b0;
         end
         // unused code: fall back to the reset state
         default: begin
            state_nxt = swg_pkg::SWG_ST_RESET;
            run_nxt = 1'b0;
            stby_nxt = 1'b0;
         end
      endcase
   end

   // registers only
   // outputs reset low: neither run nor standby while reset is held
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_r <= swg_pkg::SWG_ST_RESET;
         run_r <= 1'b0;
         stby_r <= 1'b0;
         mon_r <= `SWG_MODE_PROGRAM;
         all_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         run_r <= run_nxt;
         stby_r <= stby_nxt;
         mon_r <= mon_nxt;
         all_r <= all_nxt;
      end
   end

   // every output is a flop, no logic behind the pins
   assign o_cpu_run = run_r;
   assign o_standby = stby_r;
   assign o_mode_monitor = mon_r;
   assign o_all_done = all_r;

   // release under wait-all only after every done
   property p_wait_all;
      @(posedge i_clk) disable iff (i_rst)
      (state_r == swg_pkg::SWG_ST_STANDBY && policy_s == 1'b0 && !(units_ok && boards_ok)) |=> !run_r;
   endproperty
   a_wait_all: assert property (p_wait_all) else $error("released before all done");

   // early start with boards skipped releases at once
   property p_early_units;
      @(posedge i_clk) disable iff (i_rst)
      (state_r == swg_pkg::SWG_ST_STANDBY && policy_s && skip_s) |=> run_r;
   endproperty
   a_early_units: assert property (p_early_units) else $error("early start not taken");

   // wait-all ignores the skip bit while boards are unfinished
   property p_skip_ignored;
      @(posedge i_clk) disable iff (i_rst)
      (state_r == swg_pkg::SWG_ST_STANDBY && !policy_s && skip_s && !boards_ok) |=> stby_r;
   endproperty
   a_skip_ignored: assert property (p_skip_ignored) else $error("board skip honoured under wait-all");

   // early start with board wait holds while any board is unfinished
   property p_board_wait;
      @(posedge i_clk) disable iff (i_rst)
      (state_r == swg_pkg::SWG_ST_STANDBY && policy_s && !skip_s && !boards_ok) |=> !run_r;
   endproperty
   a_board_wait: assert property (p_board_wait) else $error("released before boards done");

   // skip bit set: release on the very next edge, units and boards not all finished
   property p_board_skip;
      @(posedge i_clk) disable iff (i_rst)
      (state_r == swg_pkg::SWG_ST_STANDBY && policy_s && skip_s && !boards_ok && !units_ok) |=> !stby_r && run_r;
   endproperty
   a_board_skip: assert property (p_board_skip) else $error("boards waited when skipped");

   // released: standby stays low and release never drops
   property p_run_excl;
      @(posedge i_clk) disable iff (i_rst)
      run_r |-> !stby_r ##1 run_r;
   endproperty
   a_run_excl: assert property (p_run_excl) else $error("run and standby overlap or run dropped");

   // wait-all releases on the edge after everything reads done
   property p_wait_all_release;
      @(posedge i_clk) disable iff (i_rst)
      (state_r == swg_pkg::SWG_ST_STANDBY && !policy_s && units_ok && boards_ok) |=> run_r;
   endproperty
   a_wait_all_release: assert property (p_wait_all_release) else $error("wait-all release missed");

   // board wait releases once boards are done, units still starting
   property p_board_release;
      @(posedge i_clk) disable iff (i_rst)
      (state_r == swg_pkg::SWG_ST_STANDBY && policy_s && !skip_s && boards_ok && !units_ok) |=> run_r;
   endproperty
   a_board_release: assert property (p_board_release) else $error("board-done release missed");

   // the reset state lasts one cycle and leads into standby
   property p_reset_to_standby;
      @(posedge i_clk) disable iff (i_rst)
      (state_r == swg_pkg::SWG_ST_RESET) |=> stby_r && !run_r;
   endproperty
   a_reset_to_standby: assert property (p_reset_to_standby) else $error("reset state skipped standby");

   // standby and run never show together
   property p_stby_excl;
      @(posedge i_clk) disable iff (i_rst)
      stby_r |-> !run_r;
   endproperty
   a_stby_excl: assert property (p_stby_excl) else $error("standby while running");

   // all-done flag rises one edge after every level reads done
   property p_all_done_set;
      @(posedge i_clk) disable iff (i_rst)
      (units_ok && boards_ok) |=> all_r;
   endproperty
   a_all_done_set: assert property (p_all_done_set) else $error("all-done flag missing");

   // all-done flag stays low while anything is unfinished
   property p_all_done_clr;
      @(posedge i_clk) disable iff (i_rst)
      !(units_ok && boards_ok) |=> !all_r;
   endproperty
   a_all_done_clr: assert property (p_all_done_clr) else $error("all-done flag too early");

   // start mode is frozen once released, whatever the pin does
   property p_mode_frozen;
      @(posedge i_clk) disable iff (i_rst)
      (state_r == swg_pkg::SWG_ST_RUN) |=> $stable(mon_r);
   endproperty
   a_mode_frozen: assert property (p_mode_frozen) else $error("start mode changed after release");
endmodule : swg_startup_gate

// ===== tb/swg_partner.sv
// far-side model: units and boards raising done levels
// assumes the bench commands each completion by go masks
`timescale 1ns/1ns
module swg_partner (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [3:0] i_unit_go, // finish these units
   input wire logic [1:0] i_board_go, // finish these boards
   output logic [3:0] o_unit_done, // unit done levels
   output logic [1:0] o_board_done // board done levels
);
   // done levels latch high and never fall before reset
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_unit_done <= 4'h0;
         o_board_done <= 2'h0;
      end else begin
         o_unit_done <= o_unit_done | i_unit_go;
         o_board_done <= o_board_done | i_board_go;
      end
   end
endmodule : swg_partner

// ===== tb/tb.sv
// self-checking bench for the startup wait gate
// assumes the partner model drives all done levels
`timescale 1ns/1ns
module tb;
   logic i_clk, i_rst, pol, skip, mode, run, stby, mon, alld;
   logic [3:0] ugo, udone;
   logic [1:0] bgo, bdone;
   int failures, n_tests;
   swg_partner swg_partner_i (.i_clk(i_clk), .i_rst(i_rst), .i_unit_go(ugo), .i_board_go(bgo),
      .o_unit_done(udone), .o_board_done(bdone));
   swg_startup_gate swg_startup_gate_i (.i_clk(i_clk), .i_rst(i_rst), .i_unit_done(udone),
      .i_board_done(bdone), .i_wait_policy(pol), .i_board_skip(skip),
      .i_start_mode(mode), .o_cpu_run(run), .o_standby(stby), .o_mode_monitor(mon), .o_all_done(alld));
   // free-running clock, 8 ns period
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   // compare {run, standby, monitor, all done}
   task automatic check(input logic [3:0] seen, input logic [3:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR t=%0t outputs %b want %b", $time, seen, exp);
      end
   endtask : check
   task automatic give_verdict;
      $display("failures=%0d n_tests=%0d", failures, n_tests);
      if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict
   // inputs move 1 ns after the edge to avoid races
   task automatic cy(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask : cy
   // reset for 4 cycles with setup bits applied, then settle
   task automatic boot(input logic p, input logic s, input logic m);
      i_rst = 1'b1;
      pol = p;
      skip = s;
      mode = m;
      ugo = 4'h0;
      bgo = 2'h0;
      cy(4);
      check({run, stby, mon, alld}, 4'b0000);
      i_rst = 1'b0;
      cy(1);
      check({run, stby, mon, alld}, 4'b0100);
      cy(7);
   endtask : boot
   // policy 0: skip bit set but must be ignored
   task automatic t_wait_all;
      boot(1'b0, 1'b1, 1'b1);
      check({run, stby, mon, alld}, 4'b0110);
      ugo = 4'h7;
      bgo = 2'h3;
      cy(8);
      check({run, stby, mon, alld}, 4'b0110);
      ugo = 4'hf;
      cy(8);
      check({run, stby, mon, alld}, 4'b1011);
   endtask : t_wait_all
   // early start waiting for boards, units never finish
   task automatic t_early_boards;
      boot(1'b1, 1'b0, 1'b0);
      check({run, stby, mon, alld}, 4'b0100);
      bgo = 2'h1;
      cy(8);
      check({run, stby, mon, alld}, 4'b0100);
      bgo = 2'h3;
      cy(3);
      check({run, stby, mon, alld}, 4'b0100);
      cy(1);
      check({run, stby, mon, alld}, 4'b1000);
   endtask : t_early_boards
   // early start skipping boards: nothing done at all
   task automatic t_early_skip;
      boot(1'b1, 1'b1, 1'b1);
      check({run, stby, mon, alld}, 4'b1010);
      mode = 1'b0;
      ugo = 4'hf;
      bgo = 2'h3;
      cy(8);
      check({run, stby, mon, alld}, 4'b1011);
   endtask : t_early_skip
   // watchdog: whole run needs under 100 cycles
   initial begin
      #5000;
      failures++;
      give_verdict();
   end
   initial begin
      failures = 0;
      n_tests = 0;
      t_wait_all();
      t_early_boards();
      t_early_skip();
      give_verdict();
   end
endmodule : tb
